// file: sgac_bank.sv
// Serial-bus target holding the sleep routing, output mode and target address registers
`timescale 1ns/1ps
`include "sgac_cfg.svh"
// Summary of operation
// - Each bit 0 to 5 of the sleep routing register picks input three (0) or six (1) as the sleep source of buck rails one to six.
// - Bits 6 and 7 of the sleep routing register pick input three (0) or six (1) for adjustable LDO rails two and three.
// - Bits 4 to 7 of the output config register pick power-good logic (0) or the software value (1) for outputs one to four.
// - Bits 0 to 2 of the output config register pick push-pull (0) or open-drain (1) drive for outputs one to three.
// - Bit 7 of the target address register selects the fixed default address (0) or the programmable field (1).
// - Bits 6 to 0 of the target address register hold the programmable 7-bit address used when the select bit is set.
module sgac_bank
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic control_input_three,
    input wire logic control_input_six,
    input wire logic [3:0] power_good,
    input wire logic [3:0] gpo_soft_value,
    output logic [7:0] sleep_req,
    output logic [3:0] gpo_out,
    output logic [3:0] gpo_oe,
    output logic [7:0] sleep_source_routing,
    output logic [7:0] general_output_config,
    output logic [7:0] bus_target_address
);
    import sgac_pkg::*;

    sgac_bank_s s;
    sgac_bank_s next_s;

    sgac_cfg_if cfg_bus();

    function automatic logic [7:0] reg_read(input logic [7:0] p, input sgac_bank_s b);
        logic [7:0] d;
        d = `SGAC_BYTE_ZERO;
        if (p == `SGAC_OFS_SLEEP_ROUTING)
        begin
            d = b.sleep_routing;
        end
        else if (p == `SGAC_OFS_OUTPUT_CONFIG)
        begin
            d = b.output_config;
        end
        else if (p == `SGAC_OFS_TARGET_ADDR)
        begin
            d = b.target_addr;
        end
        return d;
    endfunction

    always_comb
    begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic [7:0] rd;
        rise = s.scl_s2 & ~s.scl_d;
        fall = ~s.scl_s2 & s.scl_d;
        start = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
        stop = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
        rd = reg_read(s.ptr, s);
        next_s = s;
        next_s.scl_s1 = scl_in;
        next_s.scl_s2 = s.scl_s1;
        next_s.scl_d = s.scl_s2;
        next_s.sda_s1 = sda_in;
        next_s.sda_s2 = s.sda_s1;
        next_s.sda_d = s.sda_s2;

        if (start)
        begin
            next_s.st = SGAC_ADDR;
            next_s.cnt = `SGAC_BIT_ZERO;
            next_s.sda_oe = 1'b0;
            // Address sampled at each start or repeated start so a rewrite cannot cut it off
            if (s.target_addr[`SGAC_ADDR_SEL_BIT])
            begin
                next_s.active_addr = s.target_addr[`SGAC_ADDR_MSB:0];
            end
            else
            begin
                next_s.active_addr = `SGAC_DEFAULT_ADDR;
            end
        end
        else if (stop)
        begin
            next_s.st = SGAC_IDLE;
            next_s.sda_oe = 1'b0;
        end
        else
        begin
            case (s.st)
                SGAC_ADDR, SGAC_PTR, SGAC_WDATA:
                begin
                    if (rise)
                    begin
                        next_s.sh = {s.sh[6:0], s.sda_s2};
                        next_s.cnt = s.cnt + 4'h1;
                    end
                    else if (fall && s.cnt == `SGAC_BYTE_BITS)
                    begin
                        next_s.cnt = `SGAC_BIT_ZERO;
                        next_s.sda_oe = 1'b1;
                        next_s.st = SGAC_ACK;
                        if (s.st == SGAC_ADDR)
                        begin
                            // Any other address is left alone until the next start
                            if (s.sh[7:1] == s.active_addr)
                            begin
                                next_s.rw = s.sh[0];
                                next_s.got_ptr = 1'b0;
                            end
                            else
                            begin
                                next_s.sda_oe = 1'b0;
                                next_s.st = SGAC_IDLE;
                            end
                        end
                        else if (s.st == SGAC_PTR)
                        begin
                            next_s.ptr = s.sh;
                            next_s.got_ptr = 1'b1;
                        end
                        else
                        begin
                            if (s.ptr == `SGAC_OFS_SLEEP_ROUTING)
                            begin
                                next_s.sleep_routing = s.sh;
                            end
                            else if (s.ptr == `SGAC_OFS_OUTPUT_CONFIG)
                            begin
                                next_s.output_config = s.sh;
                            end
                            else if (s.ptr == `SGAC_OFS_TARGET_ADDR)
                            begin
                                next_s.target_addr = s.sh;
                            end
                            next_s.ptr = s.ptr + `SGAC_PTR_STEP;
                        end
                    end
                end
                SGAC_ACK:
                begin
                    if (fall)
                    begin
                        if (s.rw)
                        begin
                            next_s.sh = {rd[6:0], 1'b0};
                            next_s.sda_oe = ~rd[7];
                            next_s.ptr = s.ptr + `SGAC_PTR_STEP;
                            next_s.cnt = 4'h1;
                            next_s.st = SGAC_RDATA;
                        end
                        else
                        begin
                            next_s.sda_oe = 1'b0;
                            next_s.st = s.got_ptr ? SGAC_WDATA : SGAC_PTR;
                        end
                    end
                end
                SGAC_RDATA:
                begin
                    if (fall)
                    begin
                        if (s.cnt == `SGAC_BYTE_BITS)
                        begin
                            next_s.sda_oe = 1'b0;
                            next_s.st = SGAC_RACK;
                        end
                        else
                        begin
                            next_s.sda_oe = ~s.sh[7];
                            next_s.sh = {s.sh[6:0], 1'b0};
                            next_s.cnt = s.cnt + 4'h1;
                        end
                    end
                end
                SGAC_RACK:
                begin
                    if (rise)
                    begin
                        next_s.more = ~s.sda_s2;
                    end
                    else if (fall)
                    begin
                        if (s.more)
                        begin
                            next_s.sh = {rd[6:0], 1'b0};
                            next_s.sda_oe = ~rd[7];
                            next_s.ptr = s.ptr + `SGAC_PTR_STEP;
                            next_s.cnt = 4'h1;
                            next_s.st = SGAC_RDATA;
                        end
                        else
                        begin
                            next_s.st = SGAC_IDLE;
                        end
                    end
                end
                default:
                begin
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // Host is trusted to keep reserved values out of the address field; no filtering here
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= '0;
            s.st <= SGAC_IDLE;
            s.scl_s1 <= 1'b1;
            s.scl_s2 <= 1'b1;
            s.scl_d <= 1'b1;
            s.sda_s1 <= 1'b1;
            s.sda_s2 <= 1'b1;
            s.sda_d <= 1'b1;
            s.active_addr <= `SGAC_DEFAULT_ADDR;
            s.sleep_routing <= `SGAC_RST_SLEEP_ROUTING;
            s.output_config <= `SGAC_RST_OUTPUT_CONFIG;
            s.target_addr <= `SGAC_RST_TARGET_ADDR;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign cfg_bus.sleep_routing = s.sleep_routing;
    assign cfg_bus.output_config = s.output_config;

    sgac_route u_route
    (
        .clock(clock),
        .rstn(rstn),
        .cfg(cfg_bus.route),
        .control_input_three(control_input_three),
        .control_input_six(control_input_six),
        .power_good(power_good),
        .gpo_soft_value(gpo_soft_value),
        .sleep_req(sleep_req),
        .gpo_out(gpo_out),
        .gpo_oe(gpo_oe)
    );

    assign sda_out = 1'b0;
    assign sda_oe = s.sda_oe;
    assign sleep_source_routing = s.sleep_routing;
    assign general_output_config = s.output_config;
    assign bus_target_address = s.target_addr;
endmodule

// file: sgac_bank_asserts.sv
// Port-level checks of the configuration bank
`timescale 1ns/1ps
module sgac_bank_asserts
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic control_input_three,
    input wire logic control_input_six,
    input wire logic [3:0] power_good,
    input wire logic [3:0] gpo_soft_value,
    input wire logic sda_oe,
    input wire logic [7:0] sleep_req,
    input wire logic [3:0] gpo_out,
    input wire logic [3:0] gpo_oe,
    input wire logic [7:0] sleep_source_routing,
    input wire logic [7:0] general_output_config,
    input wire logic [7:0] bus_target_address
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // Four quiet samples cover both sync stages and the output flop
    property p_buck_src;
        ($stable(sleep_source_routing) && control_input_three && !control_input_six)[*4]
        |-> sleep_req[5:0] == ~sleep_source_routing[5:0];
    endproperty
    a_buck_src: assert property (p_buck_src)
        else $error("buck sleep source wrong");
    property p_ldo_src;
        ($stable(sleep_source_routing) && !control_input_three && control_input_six)[*4]
        |-> sleep_req[7:6] == sleep_source_routing[7:6];
    endproperty
    a_ldo_src: assert property (p_ldo_src)
        else $error("ldo sleep source wrong");
    property p_out_src;
        general_output_config[7] |=> gpo_oe[3] && gpo_out[3] == $past(gpo_soft_value[3]);
    endproperty
    a_out_src: assert property (p_out_src)
        else $error("output four source wrong");
    property p_drive;
        general_output_config[0] && !general_output_config[4]
        |=> !gpo_out[0] && gpo_oe[0] == !$past(power_good[0]);
    endproperty
    a_drive: assert property (p_drive)
        else $error("open drain drive wrong");
    // Acknowledge drive may only begin while the bus clock is low
    property p_ack_low;
        $rose(sda_oe) |-> !scl_in;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("data pulled while clock high");
    property p_hold;
        scl_in[*5] |-> $stable({sleep_source_routing, general_output_config, bus_target_address});
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed outside a bus bit");
    property p_ack_len;
        $rose(sda_oe) |-> sda_oe[*8];
    endproperty
    a_ack_len: assert property (p_ack_len)
        else $error("acknowledge cut short");
endmodule

bind sgac_bank sgac_bank_asserts u_chk
(
    .clock(clock),
    .rstn(rstn),
    .scl_in(scl_in),
    .control_input_three(control_input_three),
    .control_input_six(control_input_six),
    .power_good(power_good),
    .gpo_soft_value(gpo_soft_value),
    .sda_oe(sda_oe),
    .sleep_req(sleep_req),
    .gpo_out(gpo_out),
    .gpo_oe(gpo_oe),
    .sleep_source_routing(sleep_source_routing),
    .general_output_config(general_output_config),
    .bus_target_address(bus_target_address)
);

// file: sgac_cfg.svh
// Offsets, field positions, reset values and the fixed default address of the configuration bank
`ifndef SGAC_CFG_SVH
`define SGAC_CFG_SVH

`define SGAC_OFS_SLEEP_ROUTING 8'h29
`define SGAC_OFS_OUTPUT_CONFIG 8'h2A
`define SGAC_OFS_TARGET_ADDR 8'h5F

`define SGAC_RST_SLEEP_ROUTING 8'h00
`define SGAC_RST_OUTPUT_CONFIG 8'h00
`define SGAC_RST_TARGET_ADDR 8'h00

`define SGAC_DEFAULT_ADDR 7'h5E
`define SGAC_ADDR_SEL_BIT 7
`define SGAC_ADDR_MSB 6
`define SGAC_SRC_SEL_LSB 4
`define SGAC_DRIVE_LSB 0
`define SGAC_DRIVE_COUNT 3

`define SGAC_BYTE_BITS 4'h8
`define SGAC_BIT_ZERO 4'h0
`define SGAC_BYTE_ZERO 8'h00
`define SGAC_PTR_STEP 8'h01

`endif

// file: sgac_cfg_if.sv
// Register contents passed from the bank to the routing logic
`timescale 1ns/1ps
interface sgac_cfg_if;
    logic [7:0] sleep_routing;
    logic [7:0] output_config;

    modport bank
    (
        output sleep_routing,
        output output_config
    );

    modport route
    (
        input sleep_routing,
        input output_config
    );
endinterface

// file: sgac_host.sv
// Bus host model: drives the clock pin and pulls the shared data line
`timescale 1ns/1ps
module sgac_host
(
    input wire logic clock,
    input wire logic sda_in,
    output logic scl_in,
    output logic sda_pull
);
    initial
    begin
        scl_in = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // One bit time; p0 differing from p1 makes a start or stop while the clock is high
    task automatic phase(input logic p0, input logic p1, output logic s);
        w(5);
        sda_pull = p0;
        w(15);
        scl_in = 1'b1;
        w(20);
        s = sda_in;
        if (p1 != p0)
        begin
            sda_pull = p1;
            w(20);
        end
        // Only a stop leaves the clock high; every other bit ends with the clock low
        scl_in = p0 && !p1;
    endtask
    task automatic wb(input logic [7:0] d, output logic a);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            phase(!d[i], !d[i], s);
        end
        phase(1'b0, 1'b0, s);
        a = !s;
    endtask
    // Single-byte reads only, so the last bit is always a NACK
    task automatic rb(output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++)
        begin
            phase(1'b0, 1'b0, s);
            d = {d[6:0], s};
        end
        phase(1'b0, 1'b0, s);
    endtask
endmodule

// file: sgac_pkg.sv
// Types shared by the configuration bank and its output routing logic
package sgac_pkg;

    typedef enum logic [3:0] {
        SGAC_IDLE,
        SGAC_ADDR,
        SGAC_PTR,
        SGAC_WDATA,
        SGAC_ACK,
        SGAC_RDATA,
        SGAC_RACK
    } sgac_state_e;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        sgac_state_e st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic [6:0] active_addr;
        logic rw;
        logic got_ptr;
        logic more;
        logic sda_oe;
        logic [7:0] sleep_routing;
        logic [7:0] output_config;
        logic [7:0] target_addr;
    } sgac_bank_s;

    typedef struct packed {
        logic in3_s1;
        logic in3_s2;
        logic in6_s1;
        logic in6_s2;
        logic [7:0] sleep_req;
        logic [3:0] gpo_out;
        logic [3:0] gpo_oe;
    } sgac_route_s;

endpackage

// file: sgac_route.sv
// Sleep-source selection and general-purpose output drive built from the bank contents
`timescale 1ns/1ps
`include "sgac_cfg.svh"
module sgac_route
(
    input wire logic clock,
    input wire logic rstn,
    sgac_cfg_if.route cfg,
    input wire logic control_input_three,
    input wire logic control_input_six,
    input wire logic [3:0] power_good,
    input wire logic [3:0] gpo_soft_value,
    output logic [7:0] sleep_req,
    output logic [3:0] gpo_out,
    output logic [3:0] gpo_oe
);
    import sgac_pkg::*;

    sgac_route_s r;
    sgac_route_s next_r;

    always_comb
    begin
        logic v;
        v = 1'b0;
        next_r = r;
        next_r.in3_s1 = control_input_three;
        next_r.in3_s2 = r.in3_s1;
        next_r.in6_s1 = control_input_six;
        next_r.in6_s2 = r.in6_s1;
        for (int i = 0; i < 8; i++)
        begin
            // Bit set routes the rail to the sixth control input
            next_r.sleep_req[i] = cfg.sleep_routing[i] ? r.in6_s2 : r.in3_s2;
        end
        for (int i = 0; i < 4; i++)
        begin
            v = cfg.output_config[`SGAC_SRC_SEL_LSB + i] ? gpo_soft_value[i] : power_good[i];
            if (i < `SGAC_DRIVE_COUNT && cfg.output_config[`SGAC_DRIVE_LSB + i])
            begin
                // Open drain only ever pulls low
                next_r.gpo_out[i] = 1'b0;
                next_r.gpo_oe[i] = ~v;
            end
            else
            begin
                next_r.gpo_out[i] = v;
                next_r.gpo_oe[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign sleep_req = r.sleep_req;
    assign gpo_out = r.gpo_out;
    assign gpo_oe = r.gpo_oe;
endmodule

// file: testbench.sv
// Self-checking bench for the configuration bank over its serial port
`timescale 1ns/1ps
`include "sgac_cfg.svh"
module testbench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic scl_in;
    logic sda_in;
    logic sda_pull;
    logic sda_out;
    logic sda_oe;
    logic control_input_three = 1'b0;
    logic control_input_six = 1'b0;
    logic [3:0] power_good = 4'h5;
    logic [3:0] gpo_soft_value = 4'h3;
    logic [7:0] sleep_req;
    logic [3:0] gpo_out;
    logic [3:0] gpo_oe;
    logic [7:0] sleep_source_routing;
    logic [7:0] general_output_config;
    logic [7:0] bus_target_address;
    int miscompares = 0;
    int checks_done = 0;
    logic [7:0] rv [3] = '{8'h00, 8'hFF, 8'hA5};
    logic [7:0] gv [4] = '{8'h00, 8'hF0, 8'h0F, 8'hF7};
    logic [7:0] ofs [3] = '{8'h29, 8'h2A, 8'h5F};
    localparam logic [6:0] def_addr = `SGAC_DEFAULT_ADDR;
    // Pull-up on the data line: low when either side pulls
    assign sda_in = !(sda_pull || (sda_oe && !sda_out));
    always #5 clock = ~clock;
    sgac_bank u_dut
    (
        .clock(clock),
        .rstn(rstn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .control_input_three(control_input_three),
        .control_input_six(control_input_six),
        .power_good(power_good),
        .gpo_soft_value(gpo_soft_value),
        .sleep_req(sleep_req),
        .gpo_out(gpo_out),
        .gpo_oe(gpo_oe),
        .sleep_source_routing(sleep_source_routing),
        .general_output_config(general_output_config),
        .bus_target_address(bus_target_address)
    );
    sgac_host u_host
    (
        .clock(clock),
        .sda_in(sda_in),
        .scl_in(scl_in),
        .sda_pull(sda_pull)
    );
    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        checks_done++;
        if (s !== x)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
        logic q;
        u_host.phase(1'b0, 1'b1, q);
        u_host.wb({a, 1'b0}, q);
        chk({7'h00, q}, 8'h01);
        u_host.wb(o, q);
        chk({7'h00, q}, 8'h01);
        u_host.wb(d, q);
        chk({7'h00, q}, 8'h01);
        u_host.phase(1'b1, 1'b0, q);
    endtask
    // A refused address ends the transfer at once
    task automatic rd(input logic [6:0] a, input logic [7:0] o, input logic ea,
        output logic [7:0] d);
        logic q;
        d = 8'h00;
        u_host.phase(1'b0, 1'b1, q);
        u_host.wb({a, 1'b0}, q);
        chk({7'h00, q}, {7'h00, ea});
        if (q)
        begin
            u_host.wb(o, q);
            u_host.phase(1'b0, 1'b1, q);
            u_host.wb({a, 1'b1}, q);
            u_host.rb(d);
        end
        u_host.phase(1'b1, 1'b0, q);
    endtask
    initial
    begin
        repeat (60000) @(posedge clock);
        miscompares++;
        end_sim;
    end
    initial
    begin
        logic [7:0] v;
        logic [7:0] e;
        logic b;
        logic od;
        repeat (4) @(posedge clock);
        #1;
        rstn = 1'b1;
        u_host.w(4);
        for (int i = 0; i < 3; i++)
        begin
            rd(def_addr, ofs[i], 1'b1, v);
            chk(v, 8'h00);
        end
        $display("reset test done");
        foreach (rv[i])
        begin
            wr(def_addr, 8'h29, rv[i]);
            chk(sleep_source_routing, rv[i]);
            control_input_three = 1'b1;
            control_input_six = 1'b0;
            u_host.w(4);
            chk(sleep_req, ~rv[i]);
            control_input_three = 1'b0;
            control_input_six = 1'b1;
            u_host.w(4);
            chk(sleep_req, rv[i]);
        end
        rd(def_addr, 8'h29, 1'b1, v);
        chk(v, 8'hA5);
        $display("sleep routing test done");
        foreach (gv[i])
        begin
            wr(def_addr, 8'h2A, gv[i]);
            chk(general_output_config, gv[i]);
            u_host.w(2);
            for (int j = 0; j < 4; j++)
            begin
                b = gv[i][4 + j] ? gpo_soft_value[j] : power_good[j];
                od = j < 3 && gv[i][j];
                e[j] = od ? 1'b0 : b;
                e[4 + j] = od ? !b : 1'b1;
            end
            chk({gpo_oe, gpo_out}, e);
        end
        $display("output test done");
        wr(def_addr, 8'h30, 8'hFF);
        rd(def_addr, 8'h30, 1'b1, v);
        chk(v, 8'h00);
        $display("unmapped test done");
        // 0x23 is usable and clear of the second register space
        wr(def_addr, 8'h5F, 8'hA3);
        chk(bus_target_address, 8'hA3);
        rd(def_addr, 8'h5F, 1'b0, v);
        rd(7'h23, 8'h5F, 1'b1, v);
        chk(v, 8'hA3);
        wr(7'h23, 8'h5F, 8'h23);
        rd(7'h23, 8'h5F, 1'b0, v);
        rd(def_addr, 8'h5F, 1'b1, v);
        chk(v, 8'h23);
        $display("address test done");
        end_sim;
    end
endmodule
